//--- hdl/spmc_port_ctrl.v
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "spmc_map.vh"
// Mode control, status flags, pin takeover and clock generation of a serial port
module spmc_port_ctrl (
   input wire sys_clk, // System clock, 20 MHz
   input wire rst_n, // Synchronous reset, active low
   input wire ce, // Clock enable, freezes all state when low
   input wire [2:0] bus_addr, // Register index
   input wire [7:0] bus_wdata, // Write data
   input wire bus_wr, // Write strobe
   input wire bus_rd, // Read strobe
   output reg [7:0] bus_rdata, // Read data, valid the cycle after the strobe
   input wire xfer_busy, // Shifter is moving a word
   input wire rx_done, // Shifter pulse: a byte has arrived
   input wire [7:0] rx_data, // Byte from the shifter
   input wire slave_tx, // Port is transmitting as SPI or I2C slave
   input wire tmr_tick, // Periodic timer output pulse
   input wire sck_in, // SCK pin level
   input wire ss_n_in, // Slave select pin, active low
   input wire scl_in, // SCL pin level
   output reg xfer_start, // Pulse: start a master transfer
   output reg [7:0] tx_data, // Word for the shifter
   output reg spi_pins_own, // Port owns SCK, SDO, SDI, SS
   output reg ss_pin_own, // Port owns the SS pin
   output reg i2c_pins_own, // Port owns SDA and SCL
   output reg sck_out, // SCK drive level in master modes
   output reg sck_oe, // SCK output enable
   output reg sck_slave, // Synchronised SCK for slave shifting
   output reg slave_sel, // SPI slave is selected
   output reg scl_out, // SCL drive level, open drain
   output reg scl_oe, // SCL output enable, high holds SCL low
   output reg i2c_slave_on, // I2C slave function active
   output reg i2c_master_on, // I2C master function active
   output reg i2c_fw_master, // Firmware driven I2C master
   output reg addr_ten_bit, // I2C slave uses 10-bit address
   output reg start_stop_irq_en, // Start and stop interrupts enabled
   output reg brg_tick // I2C master bit clock quarter tick
);
   // Software state
   reg write_collision_flag;
   reg receive_overflow_flag;
   reg serial_port_enable;
   reg clock_polarity_release;
   reg [3:0] port_mode_select;
   reg [7:0] baud_divider_value;
   reg [7:0] transfer_buffer;
   reg buf_full;
   // Pin synchronisers
   reg sck_s1, sck_s2;
   reg ss_s1, ss_s2;
   reg scl_s1, scl_s2;
   // Decoded mode
   reg mode_valid;
   reg m_spi_master;
   reg m_spi_slave;
   reg m_i2c_slave;
   reg m_i2c_master;
   reg m_i2c_fw;
   reg [8:0] half_reload;
   wire port_on;
   wire is_master;
   wire is_slave;
   wire div_run;
   wire div_step;
   wire div_tick;
   wire wr_ctrl;
   wire wr_buf;
   wire wr_div;
   wire rd_buf;
   wire [7:0] ctrl_rd;
   wire [7:0] stat_rd;
   // Reset image of the control word
   localparam [7:0] ctrl_rst = `SPMC_CTRL_RST;

   // Mode decoder with the divider reload for each clock source
   always @* begin
      mode_valid = 1'b1;
      m_spi_master = 1'b0;
      m_spi_slave = 1'b0;
      m_i2c_slave = 1'b0;
      m_i2c_master = 1'b0;
      m_i2c_fw = 1'b0;
      half_reload = `SPMC_HALF_F4;
      case (port_mode_select)
         `SPMC_M_SPI_F4: begin
            m_spi_master = 1'b1; // R10
         end
         `SPMC_M_SPI_F16: begin
            m_spi_master = 1'b1;
            half_reload = `SPMC_HALF_F16; // R10
         end
         `SPMC_M_SPI_F64: begin
            m_spi_master = 1'b1;
            half_reload = `SPMC_HALF_F64; // R10
         end
         `SPMC_M_SPI_TMR: begin
            m_spi_master = 1'b1;
            half_reload = `SPMC_HALF_TMR; // R11
         end
         `SPMC_M_SPI_DIV: begin
            m_spi_master = 1'b1;
            half_reload = {baud_divider_value, 1'b1}; // R12
         end
         `SPMC_M_SPIS_SS, `SPMC_M_SPIS: begin
            m_spi_slave = 1'b1; // R14
         end
         `SPMC_M_I2CS7, `SPMC_M_I2CS10, `SPMC_M_I2CS7_SP, `SPMC_M_I2CS10_SP: begin
            m_i2c_slave = 1'b1; // R15 R16
         end
         `SPMC_M_I2CM: begin
            m_i2c_master = 1'b1;
            half_reload = {1'b0, baud_divider_value}; // R17
         end
         `SPMC_M_I2C_FW: begin
            m_i2c_fw = 1'b1; // R19
         end
         default: begin
            mode_valid = 1'b0; // R21
         end
      endcase
   end

   // Reserved codes leave the port off
   assign port_on = serial_port_enable & mode_valid; // R21
   assign is_master = m_spi_master | m_i2c_master | m_i2c_fw;
   assign is_slave = m_spi_slave | m_i2c_slave;

   // Timer mode counts timer pulses, other modes count system clocks
   assign div_run = port_on & ((m_spi_master & xfer_busy) | m_i2c_master);
   assign div_step = (port_mode_select == `SPMC_M_SPI_TMR) ? tmr_tick : 1'b1; // R11

   spmc_clk_div u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ce(ce),
      .run(div_run),
      .step(div_step),
      .reload(half_reload),
      .tick(div_tick)
   );

   // Bus decode
   assign wr_ctrl = bus_wr & (bus_addr == `SPMC_REG_CTRL);
   assign wr_buf = bus_wr & (bus_addr == `SPMC_REG_BUF);
   assign wr_div = bus_wr & (bus_addr == `SPMC_REG_DIV);
   assign rd_buf = bus_rd & (bus_addr == `SPMC_REG_BUF);
   // Control word as software reads it
   assign ctrl_rd = {write_collision_flag, receive_overflow_flag, serial_port_enable,
                     clock_polarity_release, port_mode_select};
   // Status word; the top bits read zero
   assign stat_rd = {3'h0, // Unused
                     scl_s2, // SCL level after the synchroniser
                     slave_sel, // SPI slave selected
                     buf_full, // Received byte not yet read
                     xfer_busy, // Shifter moving a word
                     mode_valid}; // Mode code not reserved

   // Pin synchronisers
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         ss_s1 <= 1'b1;
         ss_s2 <= 1'b1;
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
      end else if (ce) begin
         sck_s1 <= sck_in;
         sck_s2 <= sck_s1;
         ss_s1 <= ss_n_in;
         ss_s2 <= ss_s1;
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
      end
   end

   // Control register, divider and read port
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         serial_port_enable <= ctrl_rst[`SPMC_BIT_EN];
         clock_polarity_release <= ctrl_rst[`SPMC_BIT_CKP];
         port_mode_select <= ctrl_rst[`SPMC_MODE_HI:`SPMC_MODE_LO];
         baud_divider_value <= `SPMC_DIV_RST;
         bus_rdata <= 8'h00;
      end else if (ce) begin
         if (wr_ctrl) begin
            serial_port_enable <= bus_wdata[`SPMC_BIT_EN];
            clock_polarity_release <= bus_wdata[`SPMC_BIT_CKP];
            port_mode_select <= bus_wdata[`SPMC_MODE_HI:`SPMC_MODE_LO];
         end
         if (wr_div) begin
            baud_divider_value <= bus_wdata; // Zero values are a software fault
         end
         // Read data stand for one cycle, zero otherwise
         bus_rdata <= 8'h00;
         if (bus_rd) begin
            case (bus_addr)
               `SPMC_REG_CTRL: bus_rdata <= ctrl_rd;
               `SPMC_REG_BUF: bus_rdata <= transfer_buffer;
               `SPMC_REG_DIV: bus_rdata <= baud_divider_value;
               `SPMC_REG_STAT: bus_rdata <= stat_rd;
               default: bus_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Flags and the transfer buffer; hardware set wins over a software clear
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         write_collision_flag <= ctrl_rst[`SPMC_BIT_WRITE_COLLISION_FLAG];
         receive_overflow_flag <= ctrl_rst[`SPMC_BIT_OVF];
         transfer_buffer <= 8'h00;
         buf_full <= 1'b0;
         tx_data <= 8'h00;
         xfer_start <= 1'b0;
      end else if (ce) begin
         // Start pulse lasts one cycle
         xfer_start <= 1'b0;
         // Software clears a flag by writing zero to its bit
         if (wr_ctrl & ~bus_wdata[`SPMC_BIT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag <= 1'b0;
         end
         if (wr_ctrl & ~bus_wdata[`SPMC_BIT_OVF]) begin
            receive_overflow_flag <= 1'b0;
         end
         if (rd_buf) begin
            buf_full <= 1'b0;
         end
         // Hardware sets come after the clears so they win a shared cycle
         if (wr_buf & port_on) begin
            if (is_slave & xfer_busy) begin
               write_collision_flag <= 1'b1; // R1
            end else if (~xfer_busy) begin
               tx_data <= bus_wdata;
               xfer_start <= is_master; // R3
            end
         end
         // A full buffer keeps its old byte; only a receiving slave flags the loss
         if (rx_done & port_on) begin
            if (buf_full & ~rd_buf) begin
               if (is_slave & ~slave_tx) begin
                  receive_overflow_flag <= 1'b1; // R2 R3
               end
            end else begin
               transfer_buffer <= rx_data;
               buf_full <= 1'b1;
            end
         end
      end
   end

   // Pin ownership and mode outputs
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         spi_pins_own <= 1'b0;
         ss_pin_own <= 1'b0;
         i2c_pins_own <= 1'b0;
         i2c_slave_on <= 1'b0;
         i2c_master_on <= 1'b0;
         i2c_fw_master <= 1'b0;
         addr_ten_bit <= 1'b0;
         start_stop_irq_en <= 1'b0;
         slave_sel <= 1'b0;
         sck_slave <= 1'b0;
      end else if (ce) begin
         spi_pins_own <= port_on & (m_spi_master | m_spi_slave); // R4
         ss_pin_own <= port_on & (port_mode_select == `SPMC_M_SPIS_SS); // R14
         i2c_pins_own <= port_on & (m_i2c_slave | m_i2c_master | m_i2c_fw); // R5
         i2c_slave_on <= port_on & m_i2c_slave; // R19
         i2c_master_on <= port_on & (m_i2c_master | m_i2c_fw);
         i2c_fw_master <= port_on & m_i2c_fw; // R19
         // Slave configuration outputs stay low while the port is off
         addr_ten_bit <= port_on & m_i2c_slave & port_mode_select[0]; // R15
         start_stop_irq_en <= port_on & m_i2c_slave & port_mode_select[3]; // R16
         slave_sel <= port_on & m_spi_slave & (port_mode_select[0] | ~ss_s2); // R14
         sck_slave <= sck_s2;
      end
   end

   // Serial clocks: SPI master idle level and toggling, I2C slave stretching
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         brg_tick <= 1'b0;
      end else if (ce) begin
         sck_oe <= port_on & m_spi_master;
         // SPI master clock idles at the polarity level and toggles on divider ticks
         if (~(port_on & m_spi_master & xfer_busy)) begin
            sck_out <= clock_polarity_release; // R7
         end else if (div_tick) begin
            sck_out <= ~sck_out; // R10 R11 R12
         end
         scl_out <= 1'b0;
         // On SCL, polarity only matters to the slave; masters leave SCL to their sequencer
         scl_oe <= port_on & m_i2c_slave & ~clock_polarity_release; // R8 R9
         brg_tick <= port_on & m_i2c_master & div_tick; // R17
      end
   end
endmodule // spmc_port_ctrl

//--- include/spmc_map.vh
// Contract
// R1: Slave buffer write while shifting sets collision
// R2: Byte into full buffer sets overflow; the code sets it only for a slave that is not transmitting
// R3: Master operation never sets overflow
// R4: SPI enable hands SCK SDO SDI SS
// R5: I2C enable hands SDA and SCL
// R6: Software sets pin directions; I2C pins inputs
// R7: SPI polarity selects clock idle level
// R8: I2C slave polarity clear stretches SCL
// R9: I2C master ignores polarity bit
// R10: Codes 0000-0010 SPI master Fosc/4,16,64
// R11: Code 0011 SPI master timer/2
// R12: Code 1010 SPI master Fosc/(4(d+1))
// R13: Divider zero not used in SPI
// R14: Codes 0100/0101 SPI slave, select on/off
// R15: Codes 0110/0111 I2C slave 7/10-bit
// R16: Codes 1110/1111 add start/stop interrupts
// R17: Code 1000 I2C master Fosc/(4(d+1))
// R18: Divider 0,1,2 not used in I2C
// R19: Code 1011 firmware I2C master, slave idle
// R20: Codes 1001,1100,1101 reserved for software
// R21: Reserved code acts as disabled port
`ifndef SPMC_MAP_VH
`define SPMC_MAP_VH
// Register indices on the local port
`define SPMC_REG_CTRL 3'h0
`define SPMC_REG_BUF 3'h1
`define SPMC_REG_DIV 3'h2
`define SPMC_REG_STAT 3'h3
// Control register fields
`define SPMC_BIT_WRITE_COLLISION_FLAG 7
`define SPMC_BIT_OVF 6
`define SPMC_BIT_EN 5
`define SPMC_BIT_CKP 4
`define SPMC_MODE_HI 3
`define SPMC_MODE_LO 0
`define SPMC_CTRL_RST 8'h00
`define SPMC_DIV_RST 8'h00
// Status register fields
`define SPMC_BIT_VALID 0
`define SPMC_BIT_BUSY 1
`define SPMC_BIT_FULL 2
`define SPMC_BIT_SEL 3
`define SPMC_BIT_SCL 4
// Mode codes
`define SPMC_M_SPI_F4 4'h0
`define SPMC_M_SPI_F16 4'h1
`define SPMC_M_SPI_F64 4'h2
`define SPMC_M_SPI_TMR 4'h3
`define SPMC_M_SPIS_SS 4'h4
`define SPMC_M_SPIS 4'h5
`define SPMC_M_I2CS7 4'h6
`define SPMC_M_I2CS10 4'h7
`define SPMC_M_I2CM 4'h8
`define SPMC_M_RSV9 4'h9
`define SPMC_M_SPI_DIV 4'hA
`define SPMC_M_I2C_FW 4'hB
`define SPMC_M_RSVC 4'hC
`define SPMC_M_RSVD 4'hD
`define SPMC_M_I2CS7_SP 4'hE
`define SPMC_M_I2CS10_SP 4'hF
// Half-period reload counts, minus one, in system clocks; SPMC_HALF_TMR counts timer pulses
`define SPMC_HALF_F4 9'h001
`define SPMC_HALF_F16 9'h007
`define SPMC_HALF_F64 9'h01F
`define SPMC_HALF_TMR 9'h000
`endif

//--- hdl/spmc_clk_div.v
`timescale 1ns/1ns
// Reloading down counter that gives one tick per half period
module spmc_clk_div (
   input wire sys_clk, // System clock
   input wire rst_n, // Synchronous reset, active low
   input wire ce, // Clock enable
   input wire run, // Count while high, restart while low
   input wire step, // Count qualifier
   input wire [8:0] reload, // Half period minus one, in steps
   output reg tick // One-cycle pulse per half period
);
   reg [8:0] count;

   // Count steps and reload on expiry or when stopped
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         count <= 9'h000;
         tick <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (!run) begin
            count <= reload;
         end else if (step) begin
            if (count == 9'h000) begin
               count <= reload;
               tick <= 1'b1;
            end else begin
               count <= count - 9'h001;
            end
         end
      end
   end
endmodule // spmc_clk_div

//--- dv/spmc_shifter_model.sv
`timescale 1ns/1ns
// Shifter stand-in: busy after each start, received bytes on command
module spmc_shifter_model (
   input wire sys_clk, // Clock
   input wire rst_n, // Reset, active low
   input wire xfer_start, // Start pulse from the port
   input wire hold, // Bench keeps the shifter busy
   input wire rx_req, // Bench asks for one received byte
   output reg xfer_busy, // Word shifting
   output reg rx_done, // Byte arrived
   output wire [7:0] rx_data // Byte, scrambled outside its pulse
);
   reg [7:0] cnt;
   reg [7:0] rx_byte;
   // A word moves only after a start pulse
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         rx_done <= 1'b0;
         rx_byte <= 8'h40;
      end else begin
         if (xfer_start) cnt <= 8'h64;
         else if (cnt != 8'h00) cnt <= cnt - 8'h01;
         rx_done <= rx_req;
         if (rx_req) rx_byte <= rx_byte + 8'h01;
      end
   end
   // Busy level and byte lines
   always @* xfer_busy = hold || cnt != 8'h00;
   assign rx_data = rx_done ? rx_byte : ~rx_byte;
endmodule // spmc_shifter_model

//--- dv/spmc_port_ctrl_asserts.sv
`timescale 1ns/1ns
// Checks on pin takeover, clock levels and mode decoding
module spmc_port_ctrl_asserts (
   input wire sys_clk, // Clock
   input wire rst_n, // Reset, active low
   input wire ce, // Clock enable
   input wire [2:0] bus_addr, // Register index
   input wire [7:0] bus_wdata, // Write data
   input wire bus_wr, // Write strobe
   input wire xfer_busy, // Shifter busy
   input wire xfer_start, // Start pulse
   input wire spi_pins_own, // SPI pins taken
   input wire i2c_pins_own, // I2C pins taken
   input wire sck_out, // SCK level
   input wire scl_oe, // SCL held low
   input wire i2c_slave_on, // Slave active
   input wire i2c_fw_master, // Firmware master
   input wire addr_ten_bit, // 10-bit address
   input wire start_stop_irq_en // Start and stop interrupts
);
   reg [5:0] c;
   // Shadow of enable, polarity and mode
   always @(posedge sys_clk) begin
      if (!rst_n) c <= 6'h00;
      else if (ce && bus_wr && bus_addr == 3'h0) c <= bus_wdata[5:0];
   end
   // Mode groups
   wire [3:0] m = c[3:0];
   wire i2cs = c[5] && (m == 4'h6 || m == 4'h7 || m >= 4'hE);
   wire spim = c[5] && (m < 4'h4 || m == 4'hA);
   wire spi_on = c[5] && (m < 4'h6 || m == 4'hA);
   wire i2c_on = i2cs || (c[5] && (m == 4'h8 || m == 4'hB));
   wire rsv = m == 4'h9 || m == 4'hC || m == 4'hD;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_tog;
      $changed(sck_out) && xfer_busy && c[5] && m == 4'h0 && $stable(c);
   endsequence
   sequence s_quiet;
      (spim && !xfer_busy && $stable(c)) [*4];
   endsequence
   property p_spi_own; spi_pins_own == $past(spi_on); endproperty
   property p_i2c_own; i2c_pins_own == $past(i2c_on); endproperty
   property p_idle; s_quiet |-> sck_out == c[4]; endproperty
   property p_stretch; $past(i2cs) && $stable(c) |-> scl_oe == !c[4]; endproperty
   property p_f4; s_tog ##1 xfer_busy |-> $stable(sck_out) ##1 $changed(sck_out); endproperty
   property p_ten; i2c_slave_on |-> addr_ten_bit == $past(m[0]); endproperty
   property p_irq; start_stop_irq_en |-> $past(i2cs && m[3]); endproperty
   property p_fw; i2c_fw_master |-> $past(c[5] && m == 4'hB) && !i2c_slave_on; endproperty
   property p_rsv; $past(rsv) |-> !spi_pins_own && !i2c_pins_own && !xfer_start; endproperty
   property p_mst_ckp; $past(c[5] && (m == 4'h8 || m == 4'hB)) |-> !scl_oe; endproperty
   a_spi_own: assert property (p_spi_own)
      else $error("SPI pin takeover wrong");
   a_i2c_own: assert property (p_i2c_own)
      else $error("I2C pin takeover wrong");
   a_idle: assert property (p_idle)
      else $error("SCK idle level wrong");
   a_stretch: assert property (p_stretch)
      else $error("SCL stretch wrong");
   a_f4: assert property (p_f4)
      else $error("SCK half period wrong");
   a_ten: assert property (p_ten)
      else $error("Address width wrong");
   a_irq: assert property (p_irq)
      else $error("Start stop enable wrong");
   a_fw: assert property (p_fw)
      else $error("Firmware master wrong");
   a_rsv: assert property (p_rsv)
      else $error("Reserved mode active");
   a_mst_ckp: assert property (p_mst_ckp)
      else $error("Master mode holds SCL");
endmodule // spmc_port_ctrl_asserts

//--- dv/spmc_port_ctrl_test.sv
`timescale 1ns/1ns
// Bench for the serial port mode control
module spmc_port_ctrl_test;
   reg sys_clk = 1'b0;
   reg rst_n = 1'b0;
   reg [2:0] bus_addr = 3'h0;
   reg [7:0] bus_wdata = 8'h00;
   reg bus_wr = 1'b0;
   reg bus_rd = 1'b0;
   reg tmr_tick = 1'b0;
   reg ss_n_in = 1'b1;
   reg hold = 1'b0;
   reg rx_req = 1'b0;
   reg sck_in = 1'b0;
   reg scl_in = 1'b1;
   reg slave_tx = 1'b0;
   reg [2:0] tcnt = 3'h0;
   wire [7:0] bus_rdata, tx_data, rx_data;
   wire xfer_busy, rx_done, xfer_start, spi_pins_own, ss_pin_own, i2c_pins_own;
   wire sck_out, sck_oe, sck_slave, slave_sel, scl_out, scl_oe, i2c_slave_on;
   wire i2c_master_on, i2c_fw_master, addr_ten_bit, start_stop_irq_en, brg_tick;
   int error_cnt = 0;
   int compares = 0;
   int n;
   int i;
   logic [7:0] q;
   // Mode, half period in clocks
   logic [11:0] rt [0:4] = '{12'h002, 12'h108, 12'h220, 12'h305, 12'hA0C};
   // Mode, expected {i2c master, ss own, spi own, i2c own, slave, 10-bit, start stop, fw}
   logic [11:0] tb [0:10] = '{12'h020, 12'h460, 12'h618, 12'h71C, 12'h890, 12'h900,
      12'hB91, 12'hC00, 12'hD00, 12'hE1A, 12'hF1E};
   // Clock and a timer pulse every five clocks
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
      tmr_tick <= (tcnt == 3'h4);
   end
   spmc_port_ctrl spmc_port_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .xfer_busy(xfer_busy), .rx_done(rx_done), .rx_data(rx_data),
      .slave_tx(slave_tx), .tmr_tick(tmr_tick), .sck_in(sck_in), .ss_n_in(ss_n_in),
      .scl_in(scl_in), .xfer_start(xfer_start), .tx_data(tx_data),
      .spi_pins_own(spi_pins_own), .ss_pin_own(ss_pin_own), .i2c_pins_own(i2c_pins_own),
      .sck_out(sck_out), .sck_oe(sck_oe), .sck_slave(sck_slave), .slave_sel(slave_sel),
      .scl_out(scl_out), .scl_oe(scl_oe), .i2c_slave_on(i2c_slave_on),
      .i2c_master_on(i2c_master_on), .i2c_fw_master(i2c_fw_master),
      .addr_ten_bit(addr_ten_bit), .start_stop_irq_en(start_stop_irq_en),
      .brg_tick(brg_tick));
   spmc_shifter_model spmc_shifter_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .xfer_start(xfer_start), .hold(hold), .rx_req(rx_req), .xfer_busy(xfer_busy),
      .rx_done(rx_done), .rx_data(rx_data));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   task rdchk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata, exp);
   endtask
   task rx;
      @(posedge sys_clk);
      rx_req <= 1'b1;
      @(posedge sys_clk);
      rx_req <= 1'b0;
   endtask
   // Clocks between two changes of SCK, or between two brg_tick pulses, bounded
   task span(input logic brg, output int k);
      logic s;
      k = 0;
      s = brg ? 1'b0 : sck_out;
      while ((brg ? !brg_tick : sck_out === s) && k < 200) begin
         @(posedge sys_clk);
         #1 k++;
      end
      s = sck_out;
      k = 0;
      do begin
         @(posedge sys_clk);
         #1 k++;
      end while ((brg ? !brg_tick : sck_out === s) && k < 200);
   endtask
   task report_and_stop;
      if (error_cnt == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop;
   end
   // Test sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdchk(3'h0, 8'h00);
      rdchk(3'h2, 8'h00);
      wr(3'h5, 8'hFF);
      rdchk(3'h5, 8'h00);
      wr(3'h2, 8'h05);
      for (i = 0; i < 5; i++) begin
         wr(3'h0, {4'h2, rt[i][11:8]});
         wr(3'h1, 8'hA5);
         #1 chk({7'h00, xfer_start}, 8'h01);
         span(1'b0, n);
         chk(n[7:0], rt[i][7:0]);
         chk(tx_data, 8'hA5);
         for (n = 0; n < 300 && xfer_busy !== 1'b0; n++) @(posedge sys_clk);
      end
      wr(3'h0, 8'h30);
      repeat (2) @(posedge sys_clk);
      #1 chk({6'h00, sck_oe, sck_out}, 8'h03);
      wr(3'h0, 8'h20);
      rx;
      rx;
      rdchk(3'h0, 8'h20);
      rdchk(3'h1, 8'h41);
      wr(3'h0, 8'h24);
      rx;
      rx;
      rdchk(3'h0, 8'h64);
      rdchk(3'h1, 8'h43);
      hold <= 1'b1;
      wr(3'h1, 8'h11);
      rdchk(3'h0, 8'hE4);
      chk(tx_data, 8'hA5);
      hold <= 1'b0;
      wr(3'h0, 8'h24);
      rdchk(3'h0, 8'h24);
      slave_tx <= 1'b1;
      rx;
      rx;
      rdchk(3'h0, 8'h24);
      slave_tx <= 1'b0;
      rdchk(3'h1, 8'h45);
      chk({7'h00, slave_sel}, 8'h00);
      ss_n_in <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 chk({7'h00, slave_sel}, 8'h01);
      ss_n_in <= 1'b1;
      wr(3'h0, 8'h25);
      repeat (5) @(posedge sys_clk);
      #1 chk({7'h00, slave_sel}, 8'h01);
      sck_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk({7'h00, sck_slave}, 8'h01);
      rdchk(3'h3, 8'h19);
      wr(3'h0, 8'h26);
      repeat (2) @(posedge sys_clk);
      #1 chk({6'h00, scl_out, scl_oe}, 8'h01);
      wr(3'h0, 8'h36);
      repeat (2) @(posedge sys_clk);
      #1 chk({6'h00, scl_out, scl_oe}, 8'h00);
      wr(3'h2, 8'h04);
      wr(3'h0, 8'h28);
      span(1'b1, n);
      chk(n[7:0], 8'h05);
      chk({7'h00, scl_oe}, 8'h00);
      for (i = 0; i < 11; i++) begin
         wr(3'h0, {4'h2, tb[i][11:8]});
         repeat (2) @(posedge sys_clk);
         #1 chk({i2c_master_on, ss_pin_own, spi_pins_own, i2c_pins_own, i2c_slave_on,
            addr_ten_bit, start_stop_irq_en, i2c_fw_master}, tb[i][7:0]);
      end
      report_and_stop;
   end
endmodule // spmc_port_ctrl_test
bind spmc_port_ctrl spmc_port_ctrl_asserts spmc_port_ctrl_asserts_i (.sys_clk, .rst_n,
   .ce, .bus_addr, .bus_wdata, .bus_wr, .xfer_busy, .xfer_start, .spi_pins_own,
   .i2c_pins_own, .sck_out, .scl_oe, .i2c_slave_on, .i2c_fw_master, .addr_ten_bit,
   .start_stop_irq_en);
